/* hdl/cvr_top.sv */
`timescale 1ns/1ps
`include "cvr_map.svh"

module cvr_top
(
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic cmp_raw,
	output logic cmp_on,
	output cvr_pkg::cvr_pos_src_t pos_src,
	output logic neg_from_pin,
	output cvr_pkg::cvr_ana_force_t ana_force,
	output logic cmp_pin_out,
	output logic cmp_pin_oe_n,
	output cvr_pkg::cvr_ladder_t ladder,
	output logic ref_pin_a_oe_n,
	output logic ref_pin_b_oe_n,
	output logic wake_event,
	output logic irq
);
	import cvr_pkg::*;

	// ============================================================
	// Bus address phase capture.
	logic addr_take;
	logic addr_low;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [7:0] rd_addr;
	logic hit_cmp_rd;
	logic hit_ref_rd;
	logic hit_stat_rd;
	logic hit_mask_rd;

	assign addr_take = hsel & htrans[1] & hready;
	assign addr_low = haddr[31:8] == 24'h000000;
	assign rd_addr = haddr[7:0];
	assign hit_cmp_rd = rd_addr == `CVR_CMP_CTRL_OFS;
	assign hit_ref_rd = rd_addr == `CVR_REF_CTRL_OFS;
	assign hit_stat_rd = rd_addr == `CVR_IRQ_STAT_OFS;
	assign hit_mask_rd = rd_addr == `CVR_IRQ_MASK_OFS;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end
		else
		begin
			wr_pend_q <= addr_take & hwrite & (hsize == 3'h2) & addr_low;
			wr_addr_q <= rd_addr;
		end
	end

	// ============================================================
	// Write strobes in the data phase; other addresses are ignored.
	logic wr_cmp;
	logic wr_ref;
	logic wr_stat;
	logic wr_mask;

	assign wr_cmp = wr_pend_q & (wr_addr_q == `CVR_CMP_CTRL_OFS);
	assign wr_ref = wr_pend_q & (wr_addr_q == `CVR_REF_CTRL_OFS);
	assign wr_stat = wr_pend_q & (wr_addr_q == `CVR_IRQ_STAT_OFS);
	assign wr_mask = wr_pend_q & (wr_addr_q == `CVR_IRQ_MASK_OFS);

	// ============================================================
	// Comparator result synchroniser and polarity.
	logic raw_meta_q;
	logic raw_sync_q;
	logic [1:0] fill_q;
	logic settled;

	// Change events stay quiet until the pipeline holds a real sample, so reset gives no false edge.
	assign settled = fill_q == `CVR_SYNC_FILL;
	logic result_q;
	logic result_d;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			raw_meta_q <= 1'b0;
			raw_sync_q <= 1'b0;
			fill_q <= 2'h0;
		end
		else
		begin
			raw_meta_q <= cmp_raw;
			raw_sync_q <= raw_meta_q;
			fill_q <= settled ? fill_q : fill_q + 2'h1;
		end
	end

	// ============================================================
	// Control registers.
	cvr_cmp_ctrl_t cmp_q;
	cvr_cmp_ctrl_t cmp_d;
	cvr_ref_ctrl_t ref_q;
	cvr_ref_ctrl_t ref_d;
	cvr_cmp_ctrl_t cmp_wr;

	assign cmp_wr = cvr_cmp_ctrl_t'(hwdata[7:0]);
	assign result_d = cmp_q.cmp_on & (raw_sync_q ^ ~cmp_q.cmp_polarity);

	always_comb
	begin
		cmp_d = cmp_q;
		if (wr_cmp)
		begin
			cmp_d = cmp_wr;
		end
		cmp_d.cmp_result = result_q;
	end

	assign ref_d = wr_ref ? cvr_ref_ctrl_t'(hwdata[7:0]) : ref_q;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cmp_q <= cvr_cmp_ctrl_t'(`CVR_CMP_CTRL_RST);
			ref_q <= cvr_ref_ctrl_t'(`CVR_REF_CTRL_RST);
			result_q <= 1'b1;
		end
		else
		begin
			cmp_q <= cmp_d;
			ref_q <= ref_d;
			result_q <= result_d;
		end
	end

	// ============================================================
	// Change events and interrupt status.
	logic changed;
	logic [`CVR_IRQ_W-1:0] ev_set;
	logic [`CVR_IRQ_W-1:0] stat_q;
	logic [`CVR_IRQ_W-1:0] stat_d;
	logic [`CVR_IRQ_W-1:0] mask_q;
	logic [`CVR_IRQ_W-1:0] mask_d;
	logic [`CVR_IRQ_W-1:0] stat_clr;

	assign changed = settled & (result_d ^ result_q);
	assign ev_set[`CVR_IRQ_WAKE_BIT] = changed & ~cmp_q.cmp_wake_disable;
	assign ev_set[`CVR_IRQ_EDGE_BIT] = changed;
	assign stat_clr = wr_stat ? hwdata[`CVR_IRQ_W-1:0] : '0;
	assign stat_d = (stat_q & ~stat_clr) | ev_set;
	assign mask_d = wr_mask ? hwdata[`CVR_IRQ_W-1:0] : mask_q;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			stat_q <= `CVR_IRQ_W'(`CVR_IRQ_RST);
			mask_q <= `CVR_IRQ_W'(`CVR_IRQ_RST);
		end
		else
		begin
			stat_q <= stat_d;
			mask_q <= mask_d;
		end
	end

	// ============================================================
	// Pin routing and analog overrides.
	cvr_pos_src_t pos_src_d;
	cvr_ana_force_t ana_d;
	cvr_ladder_t ladder_d;
	logic pos_alt;

	assign pos_alt = ~cmp_q.cmp_pos_select;
	assign pos_src_d = cmp_q.cmp_pos_select ? CVR_POS_OWN_POS :
		(cmp_q.cmp_pos_alt_select ? CVR_POS_OTHER_POS : CVR_POS_OWN_NEG);
	assign ana_d.own_pos_pin = cmp_q.cmp_on & cmp_q.cmp_pos_select;
	assign ana_d.other_cmp_pos_pin = cmp_q.cmp_on & pos_alt & cmp_q.cmp_pos_alt_select;
	assign ana_d.own_neg_pin = cmp_q.cmp_on &
		(cmp_q.cmp_neg_select | (pos_alt & ~cmp_q.cmp_pos_alt_select));
	assign ladder_d.power_on = ref_q.ladder_power_on;
	assign ladder_d.low_range = ref_q.ref_low_range;
	assign ladder_d.level_code = ref_q.ref_level_code;
	assign ladder_d.ground_tie = ~ref_q.ladder_power_on & ref_q.ref_low_range &
		(ref_q.ref_level_code == `CVR_REF_ZERO_CODE);

	// ============================================================
	// Read data, assembled in the address phase from next-state values.
	// A write in its data phase therefore reaches a read issued right behind it.
	logic [7:0] rd_byte;

	assign rd_byte = hit_cmp_rd ? cmp_d :
		hit_ref_rd ? ref_d :
		hit_stat_rd ? 8'(stat_d) :
		hit_mask_rd ? 8'(mask_d) : 8'h00;

	// ============================================================
	// Output flip-flops.
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			cmp_on <= 1'b1;
			pos_src <= CVR_POS_OWN_POS;
			neg_from_pin <= 1'b1;
			ana_force <= 3'h0;
			cmp_pin_out <= 1'b0;
			cmp_pin_oe_n <= 1'b1;
			ladder <= 7'h00;
			ref_pin_a_oe_n <= 1'b1;
			ref_pin_b_oe_n <= 1'b1;
			wake_event <= 1'b0;
			irq <= 1'b0;
		end
		else
		begin
			hrdata <= (addr_take & ~hwrite & addr_low) ? {24'h000000, rd_byte} : 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			cmp_on <= cmp_q.cmp_on;
			pos_src <= pos_src_d;
			neg_from_pin <= cmp_q.cmp_neg_select;
			ana_force <= ana_d;
			cmp_pin_out <= result_q;
			cmp_pin_oe_n <= cmp_q.cmp_pin_drive_disable;
			ladder <= ladder_d;
			ref_pin_a_oe_n <= ~ref_q.ref_pin_a_drive;
			ref_pin_b_oe_n <= ~ref_q.ref_pin_b_drive;
			wake_event <= ev_set[`CVR_IRQ_WAKE_BIT];
			irq <= |(stat_d & mask_d);
		end
	end

endmodule

/* hdl/cvr_map.svh */
`ifndef CVR_MAP_SVH
`define CVR_MAP_SVH

// ============================================================
// Register byte offsets on the bus.
`define CVR_CMP_CTRL_OFS 8'h00
`define CVR_REF_CTRL_OFS 8'h04
`define CVR_IRQ_STAT_OFS 8'h08
`define CVR_IRQ_MASK_OFS 8'h0C

// ============================================================
// Reset values.
`define CVR_CMP_CTRL_RST 8'hFF
`define CVR_REF_CTRL_RST 8'h1F
`define CVR_IRQ_RST 8'h00

// ============================================================
// Interrupt status bit positions.
`define CVR_IRQ_WAKE_BIT 0
`define CVR_IRQ_EDGE_BIT 1
`define CVR_IRQ_W 2

// ============================================================
// Field positions inside the comparator control register.
`define CVR_CMP_RESULT_BIT 7

// ============================================================
// Level code that, with low range and the ladder off, ties the reference to ground.
`define CVR_REF_ZERO_CODE 4'h0

// ============================================================
// Edges after reset until the synchroniser and result flop hold a real sample.
`define CVR_SYNC_FILL 2'h3

`endif

/* hdl/cvr_pkg.sv */
package cvr_pkg;

	// ============================================================
	// Comparator control register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic cmp_result;
		logic cmp_pin_drive_disable;
		logic cmp_polarity;
		logic cmp_pos_alt_select;
		logic cmp_on;
		logic cmp_neg_select;
		logic cmp_pos_select;
		logic cmp_wake_disable;
	} cvr_cmp_ctrl_t;

	// ============================================================
	// Reference control register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic ladder_power_on;
		logic ref_pin_a_drive;
		logic ref_pin_b_drive;
		logic ref_low_range;
		logic [3:0] ref_level_code;
	} cvr_ref_ctrl_t;

	// ============================================================
	// Positive input source of the comparator.
	typedef enum logic [1:0] {
		CVR_POS_OWN_POS = 2'b00,
		CVR_POS_OTHER_POS = 2'b01,
		CVR_POS_OWN_NEG = 2'b10
	} cvr_pos_src_t;

	// ============================================================
	// Analog input overrides of the comparator pins.
	typedef struct packed {
		logic own_pos_pin;
		logic own_neg_pin;
		logic other_cmp_pos_pin;
	} cvr_ana_force_t;

	// ============================================================
	// Ladder settings handed to the analog reference.
	typedef struct packed {
		logic power_on;
		logic low_range;
		logic [3:0] level_code;
		logic ground_tie;
	} cvr_ladder_t;

endpackage

/* verif/cvr_top_chk.sv */
`timescale 1ns/1ps
module cvr_top_chk
(
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic cmp_on,
	input wire cvr_pkg::cvr_pos_src_t pos_src,
	input wire logic neg_from_pin,
	input wire cvr_pkg::cvr_ana_force_t ana_force,
	input wire logic cmp_pin_out,
	input wire logic cmp_pin_oe_n,
	input wire cvr_pkg::cvr_ladder_t ladder,
	input wire logic ref_pin_a_oe_n,
	input wire logic ref_pin_b_oe_n,
	input wire logic wake_event
);
	import cvr_pkg::*;
	// ====
	// Transfers seen in their data phase.
	logic tk;
	logic wr_ctl_q;
	logic wr_ref_q;
	logic zero_q;
	assign tk = hsel && htrans[1] && hready;
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wr_ctl_q <= 1'b0;
			wr_ref_q <= 1'b0;
			zero_q <= 1'b1;
		end
		else
		begin
			wr_ctl_q <= tk && hwrite && hsize == 3'h2 && haddr == 32'h0;
			wr_ref_q <= tk && hwrite && hsize == 3'h2 && haddr == 32'h4;
			zero_q <= !(tk && !hwrite) || haddr > 32'hC;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	chk_zero_wait: assert property (hreadyout && !hresp) else $error("bus answer not OKAY at once");
	chk_read_idle: assert property (zero_q |-> hrdata == 32'h0) else $error("read data not zero");
	chk_pin_drive: assert property (wr_ctl_q |-> ##2 cmp_pin_oe_n == $past(hwdata[6], 2))
		else $error("result pin enable wrong");
	chk_cmp_enable: assert property (wr_ctl_q |-> ##2 cmp_on == $past(hwdata[3], 2))
		else $error("comparator enable wrong");
	chk_neg_select: assert property (wr_ctl_q |-> ##2 neg_from_pin == $past(hwdata[2], 2))
		else $error("negative input wrong");
	chk_pos_select: assert property (wr_ctl_q |-> ##2 pos_src == ($past(hwdata[1], 2) ? CVR_POS_OWN_POS :
		$past(hwdata[4], 2) ? CVR_POS_OTHER_POS : CVR_POS_OWN_NEG)) else $error("positive input wrong");
	chk_ref_fields: assert property (wr_ref_q |-> ##2 {ladder.power_on, ref_pin_a_oe_n, ref_pin_b_oe_n,
		ladder.low_range, ladder.level_code} == ($past(hwdata[7:0], 2) ^ 8'h60)) else $error("reference wrong");
	chk_ground_tie: assert property (ladder.ground_tie == (!ladder.power_on && ladder.low_range &&
		ladder.level_code == 4'h0)) else $error("ground tie wrong");
	chk_ana_off: assert property (!cmp_on |-> ana_force == 3'b000) else $error("pin forced while off");
	chk_wake_pulse: assert property (wake_event |=> $changed(cmp_pin_out)) else $error("wake without change");
endmodule

bind cvr_top cvr_top_chk chk_u (.*);

/* verif/cvr_cmp_model.sv */
`timescale 1ns/1ps
module cvr_cmp_model
(
	input wire logic clock,
	input wire logic cmp_on,
	input wire cvr_pkg::cvr_pos_src_t pos_src,
	input wire logic neg_from_pin,
	input wire logic [7:0] own_pos,
	input wire logic [7:0] other_pos,
	input wire logic [7:0] own_neg,
	input wire logic [7:0] vref,
	output logic cmp_raw
);
	import cvr_pkg::*;
	logic [7:0] p;
	logic [7:0] n;
	assign p = pos_src == CVR_POS_OWN_POS ? own_pos : pos_src == CVR_POS_OTHER_POS ? other_pos : own_neg;
	assign n = neg_from_pin ? own_neg : vref;
	initial cmp_raw = 1'b0;
	// An idle comparator gives no stable answer.
	always @(posedge clock) cmp_raw <= cmp_on ? p > n : ~cmp_raw;
endmodule

/* verif/cvr_top_tb.sv */
`timescale 1ns/1ps
module cvr_top_tb;
	import cvr_pkg::*;
	logic clock, rst, hsel, hwrite, hrdy, hresp, cmp_raw, cmp_on, neg_from_pin, cmp_pin_out, cmp_pin_oe_n;
	logic ref_pin_a_oe_n, ref_pin_b_oe_n, wake_event, irq;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, v;
	logic [7:0] own_pos, other_pos, own_neg, vref;
	cvr_pos_src_t pos_src;
	cvr_ana_force_t ana_force;
	cvr_ladder_t ladder;
	int failures, checked;
	int wakes = 0;
	int w0;
	logic [7:0] sel_d[3] = '{8'h0A, 8'h18, 8'h08};
	logic [1:0] sel_p[3] = '{2'b00, 2'b01, 2'b10};
	logic [2:0] sel_f[3] = '{3'b100, 3'b001, 3'b010};
	logic [7:0] ref_d[3] = '{8'h10, 8'hE5, 8'h40};
	logic [6:0] ref_l[3] = '{7'h21, 7'h4A, 7'h00};
	logic [1:0] ref_o[3] = '{2'b11, 2'b00, 2'b01};
	cvr_top dut_u (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hrdy), .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp),
		.cmp_raw(cmp_raw), .cmp_on(cmp_on), .pos_src(pos_src), .neg_from_pin(neg_from_pin), .ana_force(ana_force),
		.cmp_pin_out(cmp_pin_out), .cmp_pin_oe_n(cmp_pin_oe_n), .ladder(ladder), .ref_pin_a_oe_n(ref_pin_a_oe_n),
		.ref_pin_b_oe_n(ref_pin_b_oe_n), .wake_event(wake_event), .irq(irq));
	cvr_cmp_model cmp_u (.clock(clock), .cmp_on(cmp_on), .pos_src(pos_src), .neg_from_pin(neg_from_pin),
		.own_pos(own_pos), .other_pos(other_pos), .own_neg(own_neg), .vref(vref), .cmp_raw(cmp_raw));
	always @(posedge clock) if (wake_event === 1'b1) wakes <= wakes + 1;
	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	// ====
	// Bus and check tasks.
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		while (hrdy !== 1'b1) @(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clock);
		while (hrdy !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clock);
		while (hrdy !== 1'b1) @(posedge clock);
		v = hrdata;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp, input string n);
		xfer(1'b0, a, 32'h0);
		chk(n, v, exp);
	endtask
	task idle(input int n);
		repeat (n) @(negedge clock);
	endtask
	task report_and_stop;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (3000) @(posedge clock);
		failures++;
		report_and_stop();
	end
	// ====
	// Test sequence.
	initial
	begin
		{rst, hsel, htrans, hwrite, haddr, hwdata} = {1'b1, 68'h0};
		hsize = 3'h2;
		{own_pos, other_pos, own_neg, vref} = {8'd10, 8'd40, 8'd20, 8'd30};
		{failures, checked} = 0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		idle(8);
		chk("ana_force", ana_force, 3'b110);
		chk("ladder", ladder, 7'h3E);
		chk("pin_oe", cmp_pin_oe_n, 1'b1);
		rd(8'h00, 32'h7F, "ctrl");
		rd(8'h04, 32'h1F, "ref");
		rd(8'h10, 32'h0, "unmapped");
		$display("test reset done");
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b1, 8'h00, {24'h0, sel_d[i]});
			idle(2);
			chk("pos_src", pos_src, sel_p[i]);
			chk("ana_force", ana_force, sel_f[i]);
			chk("neg", neg_from_pin, 1'b0);
			chk("on_oe", {cmp_on, cmp_pin_oe_n}, 2'b10);
		end
		xfer(1'b1, 8'h00, 32'hC4);
		idle(8);
		chk("off", {cmp_on, cmp_pin_oe_n, neg_from_pin, ana_force}, 6'h18);
		rd(8'h00, 32'h44, "ctrl");
		$display("test select done");
		own_pos <= 8'd30;
		xfer(1'b1, 8'h00, 32'h2E);
		idle(8);
		rd(8'h00, 32'hAE, "ctrl");
		chk("pin_out", cmp_pin_out, 1'b1);
		xfer(1'b1, 8'h08, 32'h3);
		w0 = wakes;
		xfer(1'b1, 8'h00, 32'h0E);
		idle(8);
		rd(8'h00, 32'h0E, "ctrl");
		chk("pin_out", cmp_pin_out, 1'b0);
		rd(8'h08, 32'h3, "status");
		chk("wake", wakes - w0, 32'h1);
		chk("irq", irq, 1'b0);
		xfer(1'b1, 8'h0C, 32'h3);
		idle(2);
		chk("irq", irq, 1'b1);
		xfer(1'b1, 8'h08, 32'h3);
		idle(2);
		chk("irq", irq, 1'b0);
		xfer(1'b1, 8'h00, 32'h0F);
		own_pos <= 8'd10;
		w0 = wakes;
		idle(8);
		rd(8'h08, 32'h2, "status");
		chk("wake", wakes - w0, 32'h0);
		chk("irq", irq, 1'b1);
		xfer(1'b1, 8'h0C, 32'h1);
		idle(2);
		chk("irq", irq, 1'b0);
		$display("test result done");
		for (int i = 0; i < 3; i++)
		begin
			xfer(1'b1, 8'h04, {24'h0, ref_d[i]});
			idle(2);
			chk("ladder", ladder, ref_l[i]);
			chk("ref_oe", {ref_pin_a_oe_n, ref_pin_b_oe_n}, ref_o[i]);
			rd(8'h04, {24'h0, ref_d[i]}, "ref");
		end
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		idle(4);
		rd(8'h04, 32'h1F, "ref");
		rd(8'h08, 32'h0, "status");
		$display("test reference done");
		report_and_stop();
	end
endmodule
